// File: tcd_defines.svh
// Constant names for the two-channel cycle-steal transfer engine
`ifndef TCD_DEFINES_SVH
`define TCD_DEFINES_SVH
`define TCD_NCH          2
`define TCD_AW           20
`define TCD_CW           16
`define TCD_DW           16
`define TCD_SELW         4
`define TCD_NSRC         16
`define TCD_SEL_SOFT     4'h1
`define TCD_CNT_TERM     16'h0000
`define TCD_ADDR_RST     20'h00000
`define TCD_DATA_RST     16'h0000
`define TCD_STEP_BYTE    20'h00001
`define TCD_STEP_WORD    20'h00002
`endif

// File: tcd_pkg.sv
// Types shared by the transfer engine files
package tcd_pkg;
   typedef struct packed {
      logic        enable;     // channel_enable_bit
      logic        repeat_md;  // 1 repeat, 0 single
      logic        word;       // 1 16-bit unit, 0 8-bit
      logic        src_inc;    // Source pointer increments
      logic        dst_inc;    // Destination pointer increments
      logic        cause_expansion_bit;
      logic [3:0]  cause_select_field;
      logic [19:0] source_pointer;
      logic [19:0] destination_pointer;
      logic [15:0] reload;
   } tcd_cfg_t;

   typedef enum logic [2:0] {
      TCD_IDLE, TCD_RD, TCD_RD2, TCD_WR, TCD_WR2
   } tcd_state_t;
endpackage

// File: tcd_req_sel.sv
// Request selection and pending flag for one channel
`timescale 1ns/1ns
`default_nettype none
`include "tcd_defines.svh"
module tcd_req_sel
   import tcd_pkg::*;
#(
   parameter int NSRC = `TCD_NSRC
) (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire tcd_cfg_t          cfg,
   input  wire logic [NSRC-1:0]   basic_req,
   input  wire logic [NSRC-1:0]   ext_req,
   input  wire logic              soft_wr,
   input  wire logic              take,
   output var  logic              pending
);
   logic       sel_q;
   logic       sel_d;
   logic       pend_d;
   wire  logic sel_hw = cfg.cause_expansion_bit ? ext_req[cfg.cause_select_field]
                                                : basic_req[cfg.cause_select_field];
   wire  logic soft_ok = soft_wr && !cfg.cause_expansion_bit &&
                         (cfg.cause_select_field == `TCD_SEL_SOFT);
   wire  logic edge_hw = sel_hw && !sel_q;

   // Request edge and soft trigger set, start of service clears; set wins
   assign sel_d  = sel_hw;
   assign pend_d = (edge_hw || soft_ok) ? cfg.enable : (pending && !take && cfg.enable);

   // Pending flag, dropped when disabled
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sel_q   <= 1'b0;
         pending <= 1'b0;
      end else begin
         sel_q   <= sel_d;
         pending <= pend_d;
      end
   end

   AST_SOFT: assert property (@(posedge mclk) disable iff (sys_rst)
      soft_wr && cfg.enable && !soft_ok && !edge_hw |=> pending == $past(pending && !take))
      else $error("soft write raised request outside soft trigger select");
endmodule
`default_nettype wire

// File: tcd_dma.sv
// Two-channel cycle-steal transfer engine, top level
`timescale 1ns/1ns
`default_nettype none
`include "tcd_defines.svh"
module tcd_dma
   import tcd_pkg::*;
#(
   parameter int AW   = `TCD_AW,
   parameter int DW   = `TCD_DW,
   parameter int NSRC = `TCD_NSRC
) (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire tcd_cfg_t               cfg0,
   input  wire tcd_cfg_t               cfg1,
   input  wire logic [NSRC-1:0]        basic_req0,
   input  wire logic [NSRC-1:0]        ext_req0,
   input  wire logic [NSRC-1:0]        basic_req1,
   input  wire logic [NSRC-1:0]        ext_req1,
   input  wire logic                   soft_wr0,
   input  wire logic                   soft_wr1,
   input  wire logic                   bus_ack,
   input  wire logic [DW-1:0]          bus_rdata,
   output var  logic                   bus_hold,
   output var  logic                   bus_rd,
   output var  logic                   bus_wr,
   output var  logic                   bus_word,
   output var  logic [AW-1:0]          bus_addr,
   output var  logic [DW-1:0]          bus_wdata,
   output var  logic [`TCD_NCH-1:0]    done_irq,
   output var  logic [`TCD_NCH-1:0]    active
);
   tcd_state_t          st_q;
   tcd_state_t          st_d;
   logic                ch_q;
   logic [AW-1:0]       ptr_q [`TCD_NCH];
   logic [`TCD_CW-1:0]  cnt_q [`TCD_NCH];
   logic [`TCD_NCH-1:0] en_q;
   logic [`TCD_NCH-1:0] fresh_q;
   logic [DW-1:0]       data_q;
   logic [`TCD_NCH-1:0] pend;
   logic [`TCD_NCH-1:0] take;
   tcd_cfg_t            cfg [`TCD_NCH];

   assign cfg[0] = cfg0;
   assign cfg[1] = cfg1;

   // Per-channel cause selection; interrupt mask is not an input at all
   tcd_req_sel #(.NSRC(NSRC)) u_sel0 (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .cfg       (cfg0),
      .basic_req (basic_req0),
      .ext_req   (ext_req0),
      .soft_wr   (soft_wr0),
      .take      (take[0]),
      .pending   (pend[0])
   );
   tcd_req_sel #(.NSRC(NSRC)) u_sel1 (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .cfg       (cfg1),
      .basic_req (basic_req1),
      .ext_req   (ext_req1),
      .soft_wr   (soft_wr1),
      .take      (take[1]),
      .pending   (pend[1])
   );

   // Arbitration: channel zero first, illegal both-increment setups refused
   wire logic [`TCD_NCH-1:0] legal;
   assign legal[0] = !(cfg0.src_inc && cfg0.dst_inc);
   assign legal[1] = !(cfg1.src_inc && cfg1.dst_inc);
   wire logic [`TCD_NCH-1:0] runnable = pend & legal & active & {cfg1.enable, cfg0.enable};
   wire logic idle  = (st_q == TCD_IDLE);
   wire logic start = idle && (runnable != '0);
   wire logic pick  = !runnable[0];
   assign take[0] = start && !pick;
   assign take[1] = start && pick;

   // Current channel view, with first-transfer reload; picked channel while idle
   wire logic           sel_ch = idle ? pick : ch_q;
   tcd_cfg_t             cc;
   assign cc = cfg[sel_ch];
   wire logic [AW-1:0]  cur_ptr = fresh_q[sel_ch] ?
                                  (cc.src_inc ? cc.source_pointer : cc.destination_pointer)
                                  : ptr_q[sel_ch];
   wire logic [`TCD_CW-1:0] cur_cnt = fresh_q[sel_ch] ? cc.reload : cnt_q[sel_ch];
   wire logic [AW-1:0]  src_a = cc.src_inc ? cur_ptr : cc.source_pointer;
   wire logic [AW-1:0]  dst_a = cc.dst_inc ? cur_ptr : cc.destination_pointer;
   wire logic [AW-1:0]  step  = cc.word ? `TCD_STEP_WORD : `TCD_STEP_BYTE;
   wire logic           under = (cur_cnt == `TCD_CNT_TERM);
   wire logic           src_odd = cc.word && src_a[0];
   wire logic           dst_odd = cc.word && dst_a[0];
   wire logic           fin = bus_ack && ((st_q == TCD_WR2) || (st_q == TCD_WR && !dst_odd));

   // Read, optional second read, write, optional second write
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         TCD_IDLE: if (start) st_d = TCD_RD;
         TCD_RD:   if (bus_ack) st_d = src_odd ? TCD_RD2 : TCD_WR;
         TCD_RD2:  if (bus_ack) st_d = TCD_WR;
         TCD_WR:   if (bus_ack) st_d = dst_odd ? TCD_WR2 : TCD_IDLE;
         TCD_WR2:  if (bus_ack) st_d = TCD_IDLE;
      endcase
   end

   // Sequencer and bus outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q      <= TCD_IDLE;
         ch_q      <= 1'b0;
         data_q    <= `TCD_DATA_RST;
         bus_hold  <= 1'b0;
         bus_rd    <= 1'b0;
         bus_wr    <= 1'b0;
         bus_word  <= 1'b0;
         bus_addr  <= `TCD_ADDR_RST;
         bus_wdata <= `TCD_DATA_RST;
      end else begin
         st_q <= st_d;
         if (start)
            ch_q <= pick;
         if (bus_ack && (st_q == TCD_RD || st_q == TCD_RD2))
            data_q <= bus_rdata;
         bus_hold  <= (st_d != TCD_IDLE);
         bus_rd    <= (st_d == TCD_RD) || (st_d == TCD_RD2);
         bus_wr    <= (st_d == TCD_WR) || (st_d == TCD_WR2);
         bus_word  <= cc.word;
         bus_addr  <= (st_d == TCD_WR || st_d == TCD_WR2) ? dst_a : src_a;
         bus_wdata <= (bus_ack && (st_q == TCD_RD || st_q == TCD_RD2)) ? bus_rdata : data_q;
      end
   end

   // Per-channel pointer, counter, enable and completion event
   for (genvar i = 0; i < `TCD_NCH; i++) begin : g_ch
      wire logic mine = fin && (ch_q == i);
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            ptr_q[i]    <= `TCD_ADDR_RST;
            cnt_q[i]    <= `TCD_CNT_TERM;
            en_q[i]     <= 1'b0;
            fresh_q[i]  <= 1'b0;
            active[i]   <= 1'b0;
            done_irq[i] <= 1'b0;
         end else begin
            en_q[i]     <= cfg[i].enable;
            done_irq[i] <= mine && under;
            if (cfg[i].enable && !en_q[i]) begin
               fresh_q[i] <= 1'b1;
               active[i]  <= 1'b1;
            end else if (!cfg[i].enable) begin
               active[i]  <= 1'b0;
            end else if (mine) begin
               fresh_q[i] <= 1'b0;
               ptr_q[i]   <= cur_ptr + step;
               cnt_q[i]   <= under ? cfg[i].reload : cur_cnt - 1'b1;
               if (under && !cfg[i].repeat_md)
                  active[i] <= 1'b0;
            end
         end
      end
   end

   AST_PRIO: assert property (@(posedge mclk) disable iff (sys_rst)
      idle && runnable[0] && runnable[1] |=> st_q == TCD_RD && ch_q == 1'b0)
      else $error("channel one served ahead of channel zero");
   AST_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      start |=> bus_hold && bus_rd)
      else $error("bus not claimed after start");
   AST_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
      bus_rd && !bus_wr && $past(bus_wr) |-> 1'b0)
      else $error("read after write inside one transfer");
   AST_EN: assert property (@(posedge mclk) disable iff (sys_rst)
      start |-> (take[0] ? cfg0.enable : cfg1.enable))
      else $error("transfer started on disabled channel");
   AST_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
      fin && under |=> done_irq[$past(ch_q)])
      else $error("no interrupt at underflow");
   AST_SINGLE: assert property (@(posedge mclk) disable iff (sys_rst)
      fin && under && !cc.repeat_md && cc.enable && en_q[ch_q] |=> !active[$past(ch_q)])
      else $error("single mode kept running after underflow");
   AST_ODD: assert property (@(posedge mclk) disable iff (sys_rst)
      st_q == TCD_RD && bus_ack && src_odd |=> st_q == TCD_RD2)
      else $error("odd word source missing extra read");
   AST_INC: assert property (@(posedge mclk) disable iff (sys_rst)
      start |-> !(cfg[pick].src_inc && cfg[pick].dst_inc))
      else $error("both pointers incrementing");
endmodule
`default_nettype wire

// File: tcd_mem_model.sv
// Memory and bus responder standing in for the CPU side of the shared bus
`timescale 1ns/1ns
`default_nettype none
module tcd_mem_model (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   input  wire logic [19:0] bus_addr,
   input  wire logic        slow,
   output var  logic        bus_ack,
   output var  logic [15:0] bus_rdata
);
   logic [1:0]  wait_q;
   logic [15:0] pat_q;
   // Ack each bus cycle once, at once or after two wait states
   always_ff @(posedge mclk) begin
      pat_q <= sys_rst ? 16'h0000 : pat_q + 16'h3b1d;
      if (sys_rst || bus_ack || !(bus_rd || bus_wr)) begin
         bus_ack <= 1'b0;
         wait_q  <= slow ? 2'h2 : 2'h0;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else begin
         bus_ack <= 1'b1;
      end
   end
   // Data valid only with the read ack; a moving pattern otherwise
   assign bus_rdata = (bus_ack && bus_rd) ? {bus_addr[7:0] ^ 8'ha5, bus_addr[7:0]} : pat_q;
endmodule
`default_nettype wire

// File: tb_two_channel_cycle_steal_dma.sv
// Testbench comparing bus writes with a queue model of expected transfers
`timescale 1ns/1ns
`default_nettype none
module tb_two_channel_cycle_steal_dma;
   import tcd_pkg::*;
   logic        mclk, sys_rst, soft_wr0, soft_wr1, slow, bus_ack;
   logic        bus_hold, bus_rd, bus_wr, bus_word;
   logic [15:0] basic_req1, ext_req1, bus_rdata, bus_wdata;
   logic [19:0] bus_addr, s0, d0, s1, d1;
   logic [1:0]  done_irq, active;
   logic [31:0] seed, tmp;
   logic [35:0] exp_q[$], got_q[$];
   tcd_cfg_t    cfg0, cfg1;
   int          err_count, checked, rd_n, irq_n[2];

   tcd_dma tcd_dma_i (.mclk(mclk), .sys_rst(sys_rst), .cfg0(cfg0), .cfg1(cfg1),
      .basic_req0(16'h0000), .ext_req0(16'h0000), .basic_req1(basic_req1),
      .ext_req1(ext_req1), .soft_wr0(soft_wr0), .soft_wr1(soft_wr1), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .bus_hold(bus_hold), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .done_irq(done_irq), .active(active));
   tcd_mem_model tcd_mem_model_i (.mclk(mclk), .sys_rst(sys_rst), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .slow(slow), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata));

   // Log completed writes, reads and underflow pulses
   always @(posedge mclk) begin
      if (bus_wr && bus_ack) got_q.push_back({bus_addr, bus_word ? bus_wdata : {8'h00, bus_wdata[7:0]}});
      if (bus_rd && bus_ack) rd_n++;
      for (int i = 0; i < 2; i++) if (done_irq[i]) irq_n[i]++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Flags: enable, repeat, word, src_inc, dst_inc, expansion
   function automatic tcd_cfg_t mk(input logic [19:0] s, d, input logic [5:0] f,
                                   input logic [3:0] sel, input logic [15:0] rl);
      tcd_cfg_t c;
      c = '0;
      {c.enable, c.repeat_md, c.word, c.src_inc, c.dst_inc, c.cause_expansion_bit} = f;
      c.cause_select_field = sel;
      c.source_pointer = s;
      c.destination_pointer = d;
      c.reload = rl;
      return c;
   endfunction

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [35:0] g, e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Model of one unit: write to d of what the memory holds at s
   task automatic want(input logic [19:0] s, d, input logic w);
      logic [15:0] v;
      v = {s[7:0] ^ 8'ha5, s[7:0]};
      exp_q.push_back({d, w ? v : {8'h00, v[7:0]}});
   endtask
   task automatic drain();
      while (exp_q.size() > 0) cmp(got_q.size() > 0 ? got_q.pop_front() : '1, exp_q.pop_front());
      cmp(36'(got_q.size()), 36'h0);
      got_q.delete();
   endtask
   // One request cycle, then wait for four quiet cycles on the bus
   task automatic fire(input logic a, b, input logic [15:0] bq, eq);
      int n, q;
      soft_wr0 <= a;
      soft_wr1 <= b;
      basic_req1 <= bq;
      ext_req1 <= eq;
      @(posedge mclk);
      {soft_wr0, soft_wr1, basic_req1, ext_req1} <= '0;
      n = 0;
      q = 0;
      while (q < 4 && n < 300) begin
         @(negedge mclk);
         n++;
         q = bus_hold ? 0 : q + 1;
      end
      if (n == 300) begin
         err_count++;
         tally_and_finish();
      end
      @(posedge mclk);
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Channel setups in this run never have both pointers incrementing
   initial begin
      seed = 32'h19f3;
      {sys_rst, soft_wr0, soft_wr1, slow, basic_req1, ext_req1} = {1'b1, 35'h0};
      cfg0 = '0;
      cfg1 = '0;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      tmp = rnd();
      s0 = {4'h1, tmp[15:0]};
      d0 = {12'h800, tmp[23:16]};
      cfg0 <= mk(s0, d0, 6'b000100, 4'h1, 16'h0002);
      @(posedge mclk);
      cfg0.enable <= 1'b1;
      repeat (4) fire(1, 0, 0, 0);
      want(s0, d0, 0);
      want(s0 + 1, d0, 0);
      want(s0 + 2, d0, 0);
      drain();
      cmp(36'(irq_n[0]), 36'h1);
      cmp(36'(active[0]), 36'h0);
      cfg0 <= mk(s0, d0, 6'b010100, 4'h1, 16'h0000);
      fire(1, 0, 0, 0);
      drain();
      cfg0.enable <= 1'b1;
      repeat (2) fire(1, 0, 0, 0);
      want(s0, d0, 0);
      want(s0 + 1, d0, 0);
      drain();
      cmp(36'(irq_n[0]), 36'h3);
      tmp = rnd();
      s1 = {4'h3, tmp[15:1], 1'b1};
      d1 = 20'h90000;
      cfg1 <= mk(s1, d1, 6'b001010, 4'h5, 16'h0001);
      @(posedge mclk);
      cfg1.enable <= 1'b1;
      fire(0, 1, 0, 0);
      drain();
      rd_n = 0;
      fire(0, 0, 16'h0020, 0);
      cfg1 <= mk(s1, d1, 6'b101011, 4'h3, 16'h0001);
      fire(0, 0, 0, 16'h0008);
      want(s1, d1, 1);
      want(s1, d1 + 2, 1);
      drain();
      cmp(36'(rd_n), 36'h4);
      cmp(36'(irq_n[1]), 36'h1);
      cfg0 <= mk(s0, d0, 6'b000100, 4'h1, 16'h0000);
      cfg1 <= mk(s1, d1, 6'b000000, 4'h1, 16'h0000);
      slow <= 1'b1;
      @(posedge mclk);
      cfg0.enable <= 1'b1;
      cfg1.enable <= 1'b1;
      fire(1, 1, 0, 0);
      want(s0, d0, 0);
      want(s1, d1, 0);
      drain();
      tally_and_finish();
   end
endmodule
`default_nettype wire
